// File: rtl/clock_gen_map.svh
`ifndef CLOCK_GEN_MAP_SVH
`define CLOCK_GEN_MAP_SVH
`define MULT_RESET 7'h15
`define ADJUST_RESET 8'h80
`define STAB_CYCLES_CRYSTAL 4096
`define STAB_CYCLES_EXTERNAL 16
`define MULT_W 7
`define ADJUST_W 8
`define DIV_W 4
`define STAGE_W 8
`define SETTLE_CYCLES 32
`endif

// File: rtl/clock_gen_pkg.sv
package clock_gen_pkg;
  typedef enum logic [1:0] {
    RANGE_CRYSTAL = 2'h0,
    RANGE_EXT_FAST = 2'h1,
    RANGE_EXT_SLOW = 2'h2
  } monitor_range_t;
  typedef enum logic [2:0] {
    STAB_IDLE = 3'h1,
    STAB_COUNT = 3'h2,
    STAB_DONE = 3'h4
  } stab_state_t;
endpackage

// File: rtl/ext_stab_divider.sv
`include "clock_gen_map.svh"
module ext_stab_divider
  import clock_gen_pkg::*;
#(
  parameter int LONG_COUNT = `STAB_CYCLES_CRYSTAL,
  parameter int SHORT_COUNT = `STAB_CYCLES_EXTERNAL
) (
  input wire logic clk, // Bus clock
  input wire logic reset_n, // Async reset
  input wire logic enable, // Count while high, restart when low
  input wire logic longMode, // Crystal timeout selected
  input wire logic extEdge, // One external clock cycle seen
  output logic stable // Timeout reached
);
  localparam int CW = $clog2(LONG_COUNT + 1);
  initial begin
    if (SHORT_COUNT < 1 || LONG_COUNT < SHORT_COUNT)
      $error("ext_stab_divider: bad counts");
  end
  stab_state_t state;
  logic [CW-1:0] count;
  logic [CW-1:0] target;
  assign target = longMode ? CW'(LONG_COUNT) : CW'(SHORT_COUNT);
  assign stable = (state == STAB_DONE);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= STAB_IDLE;
      count <= '0;
    end else if (!enable) begin
      state <= STAB_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        STAB_IDLE: begin
          state <= STAB_COUNT;
        end
        STAB_COUNT: begin
          if (extEdge) begin
            if (count + CW'(1) >= target) begin
              state <= STAB_DONE;
            end
            count <= count + CW'(1);
          end
        end
        STAB_DONE: begin
          state <= STAB_DONE;
        end
      endcase
    end
  end
endmodule

// File: rtl/int_settle_timer.sv
`include "clock_gen_map.svh"
module int_settle_timer #(
  parameter int SETTLE = `SETTLE_CYCLES
) (
  input wire logic clk, // Bus clock
  input wire logic reset_n, // Async reset
  input wire logic restart, // Factor written or stop mode entered
  input wire logic genOn, // Internal generator enabled
  input wire logic locked, // Loop reports within tolerance
  output logic stable // Settled
);
  localparam int CW = $clog2(SETTLE + 1);
  initial begin
    if (SETTLE < 1)
      $error("int_settle_timer: bad settle count");
  end
  logic [CW-1:0] count;
  assign stable = genOn && locked && (count == CW'(SETTLE));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (restart || !genOn || !locked) begin
      count <= '0;
    end else if (count != CW'(SETTLE)) begin
      count <= count + CW'(1);
    end
  end
endmodule

// File: rtl/clock_gen_interlock.sv
`include "clock_gen_map.svh"
module clock_gen_interlock
  import clock_gen_pkg::*;
#(
  parameter int MULT_W = `MULT_W,
  parameter int ADJUST_W = `ADJUST_W,
  parameter int DIV_W = `DIV_W,
  parameter int STAGE_W = `STAGE_W,
  parameter int LONG_COUNT = `STAB_CYCLES_CRYSTAL,
  parameter int SHORT_COUNT = `STAB_CYCLES_EXTERNAL
) (
  input wire logic clk, // 40 MHz bus clock
  input wire logic reset_n, // Async reset, active low
  input wire logic cfgExtInput, // Option from config storage
  input wire logic cfgCrystal, // Option from config storage
  input wire logic cfgLowFreq, // Option from config storage
  input wire logic cfgRunInStop, // Option from config storage
  input wire logic stopMode, // Stop mode active
  input wire logic ctrlWrite, // Control write strobe
  input wire logic wrIrqEnable, // Written monitor interrupt enable
  input wire logic wrFaultFlag, // Written monitor flag
  input wire logic wrMonitorOn, // Written monitor on
  input wire logic wrClockSelect, // Written clock select
  input wire logic wrInternalOn, // Written internal on
  input wire logic wrExternalOn, // Written external on
  input wire logic ctrlRead, // Control read strobe
  input wire logic multWrite, // Multiplier write strobe
  input wire logic [MULT_W-1:0] multData, // Multiplier write data
  input wire logic adjustWrite, // Adjust write strobe
  input wire logic [ADJUST_W-1:0] adjustData, // Adjust write data
  input wire logic divWrite, // Divider write strobe
  input wire logic [DIV_W-1:0] divData, // Divider write data
  input wire logic stageWrite, // Stage write strobe
  input wire logic [STAGE_W-1:0] stageData, // Stage write data
  input wire logic internalLocked, // Loop within tolerance
  input wire logic externalEdge, // One external clock cycle
  input wire logic internalClockDead, // Monitor saw internal stop
  input wire logic externalClockDead, // Monitor saw external stop
  input wire logic oscInputPinIn, // Input pin level
  input wire logic portOutputData, // Port data for output pin
  input wire logic portOutputEnable, // Port drive for output pin
  input wire logic srcOscClock, // Selected source clock
  input wire logic srcSystemClock, // System clock source
  input wire logic srcTimebaseClock, // Timebase clock source
  output logic monitorIrqEnable, // Status bit
  output logic monitorFaultFlag, // Status bit
  output logic monitorOn, // Status bit
  output logic clockSelect, // Status bit
  output logic internalGenOn, // Status bit
  output logic externalGenOn, // Status bit
  output logic internalGenStable, // Status bit
  output logic externalGenStable, // Status bit
  output logic [MULT_W-1:0] multiplier, // Multiplier factor
  output logic [ADJUST_W-1:0] adjustFactor, // Adjust factor
  output logic [DIV_W-1:0] divider, // Divider count
  output logic [STAGE_W-1:0] stage, // Stage count
  output logic oscInputIsClock, // Input pin in oscillator function
  output logic ampEnable, // Crystal amplifier drives output pin
  output logic ampLowDrive, // Reduced amplifier drive
  output monitor_range_t monitorRange, // Expected external range
  output logic oscOutputPinOut, // Output pin data
  output logic oscOutputPinOe, // Output pin enable
  output logic oscillatorOutputClock, // Gated oscillator clock
  output logic systemClockOut, // Gated system clock
  output logic timebaseClock, // Gated timebase clock
  output logic irqRequest // Monitor interrupt request
);
  initial begin
    if (MULT_W < 1 || ADJUST_W < 1 || DIV_W < 1 || STAGE_W < 1)
      $error("clock_gen_interlock: bad widths");
  end

  logic optExt, optXtal, optSlow, optRun, sampled;
  logic stopClear, flagArmed, settleRestart, intStableRaw, extStableRaw;
  logic factorLock, stageLock;
  logic next_irqEnable, next_flag, next_monOn, next_select;
  logic next_intOn, next_extOn;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      optExt <= 1'b0;
      optXtal <= 1'b0;
      optSlow <= 1'b0;
      optRun <= 1'b0;
      sampled <= 1'b0;
    end else if (!sampled) begin
      optExt <= cfgExtInput;
      optXtal <= cfgCrystal;
      optSlow <= cfgLowFreq;
      optRun <= cfgRunInStop;
      sampled <= 1'b1;
    end
  end

  assign stopClear = stopMode && !optRun;
  assign factorLock = monitorOn || monitorFaultFlag;
  assign stageLock = factorLock || !optExt || !clockSelect
    || internalGenOn;

  // Combine requested control bits with forcing and blocking terms
  always_comb begin
    next_irqEnable = monitorIrqEnable;
    next_monOn = monitorOn;
    next_select = clockSelect;
    next_intOn = internalGenOn;
    next_extOn = externalGenOn;
    next_flag = monitorFaultFlag;
    if (ctrlWrite) begin
      next_irqEnable = wrIrqEnable;
      next_monOn = wrMonitorOn;
      next_select = wrClockSelect;
      next_intOn = wrInternalOn;
      next_extOn = wrExternalOn;
      if (flagArmed && !wrFaultFlag)
        next_flag = 1'b0;
      // Setting blocked by unstable generators
      if (!internalGenStable || !externalGenStable) begin
        if (!monitorIrqEnable)
          next_irqEnable = 1'b0;
        if (!monitorOn)
          next_monOn = 1'b0;
      end
      if (!internalGenStable && clockSelect)
        next_select = 1'b1;
      if (!externalGenStable && !clockSelect)
        next_select = 1'b0;
      if (!monitorOn)
        next_irqEnable = 1'b0;
      if (!optExt)
        next_extOn = 1'b0;
    end
    // Dead clock detection while monitoring
    if (monitorOn && internalGenOn && externalGenOn) begin
      if (internalClockDead) begin
        next_flag = 1'b1;
        next_select = 1'b1;
      end else if (externalClockDead) begin
        next_flag = 1'b1;
        next_select = 1'b0;
      end
    end
    if (next_flag)
      next_monOn = 1'b1;
    if (next_monOn) begin
      next_intOn = 1'b1;
      next_extOn = 1'b1;
    end
    if (!next_select)
      next_intOn = 1'b1;
    else
      next_extOn = 1'b1;
    if (!next_intOn || !next_extOn) begin
      next_irqEnable = 1'b0;
      next_flag = 1'b0;
      next_monOn = 1'b0;
      next_select = next_extOn;
    end
    if (!optExt) begin
      next_irqEnable = 1'b0;
      next_flag = 1'b0;
      next_monOn = 1'b0;
      next_select = 1'b0;
      next_extOn = 1'b0;
      next_intOn = 1'b1;
    end
    if (stopClear) begin
      next_irqEnable = 1'b0;
      next_flag = 1'b0;
      next_monOn = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monitorIrqEnable <= 1'b0;
      monitorFaultFlag <= 1'b0;
      monitorOn <= 1'b0;
      clockSelect <= 1'b0;
      internalGenOn <= 1'b1;
      externalGenOn <= 1'b0;
    end else begin
      monitorIrqEnable <= next_irqEnable;
      monitorFaultFlag <= next_flag;
      monitorOn <= next_monOn;
      clockSelect <= next_select;
      internalGenOn <= next_intOn;
      externalGenOn <= next_extOn;
    end
  end

  // Flag read while set arms the clear; a control write or a clear flag disarms it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagArmed <= 1'b0;
    end else if (!monitorFaultFlag || ctrlWrite) begin
      flagArmed <= 1'b0;
    end else if (ctrlRead) begin
      flagArmed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multiplier <= `MULT_RESET;
      adjustFactor <= `ADJUST_RESET;
    end else begin
      if (multWrite && !factorLock && !monitorIrqEnable)
        multiplier <= multData;
      if (adjustWrite && !factorLock && !monitorIrqEnable)
        adjustFactor <= adjustData;
    end
  end

  // Divider and stage are not reset: they follow the running oscillator
  always_ff @(posedge clk) begin
    if (divWrite && !stageLock)
      divider <= divData;
    if (stageWrite && !stageLock)
      stage <= stageData;
  end

  assign settleRestart = ((multWrite || adjustWrite) && !factorLock
    && !monitorIrqEnable) || stopClear;

  int_settle_timer u_int_settle (
    .clk(clk),
    .reset_n(reset_n),
    .restart(settleRestart),
    .genOn(internalGenOn),
    .locked(internalLocked && !(monitorOn && internalClockDead)),
    .stable(intStableRaw)
  );

  ext_stab_divider #(
    .LONG_COUNT(LONG_COUNT),
    .SHORT_COUNT(SHORT_COUNT)
  ) u_ext_stab (
    .clk(clk),
    .reset_n(reset_n),
    .enable(externalGenOn && optExt && !stopClear
      && !(monitorOn && externalClockDead)),
    .longMode(optXtal),
    .extEdge(externalEdge),
    .stable(extStableRaw)
  );

  assign internalGenStable = intStableRaw;
  assign externalGenStable = extStableRaw && optExt;

  assign oscInputIsClock = optExt && externalGenOn;
  assign ampEnable = optXtal && optExt && externalGenOn;
  assign ampLowDrive = optSlow && optExt && optXtal;
  assign monitorRange = optXtal ? RANGE_CRYSTAL
    : (optSlow ? RANGE_EXT_SLOW : RANGE_EXT_FAST);
  assign oscOutputPinOut = ampEnable ? !oscInputPinIn : portOutputData;
  assign oscOutputPinOe = ampEnable || portOutputEnable;

  assign oscillatorOutputClock = srcOscClock && !stopClear;
  assign systemClockOut = srcSystemClock && !stopClear;
  assign timebaseClock = srcTimebaseClock && !stopClear;
  assign irqRequest = monitorIrqEnable && monitorFaultFlag;
endmodule

// File: sim/clock_gen_interlock_asserts.sv
module clock_gen_interlock_asserts
  import clock_gen_pkg::*;
#(
  parameter int MULT_W = 7
) (
  input wire logic clk, // Bus clock
  input wire logic reset_n, // Async reset
  input wire logic cfgExtInput, // Option
  input wire logic cfgCrystal, // Option
  input wire logic cfgLowFreq, // Option
  input wire logic cfgRunInStop, // Option
  input wire logic stopMode, // Stop mode
  input wire logic multWrite, // Multiplier strobe
  input wire logic internalClockDead, // Internal lost
  input wire logic externalClockDead, // External lost
  input wire logic monitorIrqEnable, // Status
  input wire logic monitorFaultFlag, // Status
  input wire logic monitorOn, // Status
  input wire logic clockSelect, // Status
  input wire logic internalGenOn, // Status
  input wire logic externalGenOn, // Status
  input wire logic internalGenStable, // Status
  input wire logic externalGenStable, // Status
  input wire logic [MULT_W-1:0] multiplier, // Factor
  input wire logic oscInputIsClock, // Pin function
  input wire logic ampEnable, // Amplifier on
  input wire monitor_range_t monitorRange, // Range
  input wire logic oscillatorOutputClock, // Clock
  input wire logic systemClockOut, // Clock
  input wire logic timebaseClock // Clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic up;
  // Options are only valid once captured after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up <= 1'b0;
    else up <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ext_off_a: assert property (up && !cfgExtInput |-> !externalGenOn &&
    !oscInputIsClock && internalGenOn && !monitorOn && !clockSelect)
    else $error("external path active without option");
  amp_gate_a: assert property (up |-> ampEnable ==
    (cfgCrystal && cfgExtInput && externalGenOn))
    else $error("amplifier enable wrong");
  slow_range_a: assert property (up && !cfgCrystal && cfgExtInput |->
    monitorRange == (cfgLowFreq ? RANGE_EXT_SLOW : RANGE_EXT_FAST))
    else $error("monitor range wrong");
  stop_low_a: assert property (stopMode && !cfgRunInStop |->
    !oscillatorOutputClock && !systemClockOut && !timebaseClock)
    else $error("clock running in stop");
  stop_clear_a: assert property (up && stopMode && !cfgRunInStop |=>
    !monitorOn && !monitorIrqEnable && !internalGenStable && !externalGenStable)
    else $error("stop did not clear monitor state");
  flag_forces_a: assert property (monitorFaultFlag |->
    monitorOn && internalGenOn && externalGenOn)
    else $error("flag does not force generators");
  mult_lock_a: assert property (monitorOn && multWrite |=>
    $stable(multiplier))
    else $error("multiplier written while monitoring");
  factor_unstable_a: assert property (multWrite && !monitorOn &&
    !monitorFaultFlag && !monitorIrqEnable |=> !internalGenStable)
    else $error("factor write kept internal stable");
  select_force_a: assert property (clockSelect ? externalGenOn
    : internalGenOn)
    else $error("selected generator off");
  int_dead_a: assert property (monitorOn && internalClockDead &&
    !externalClockDead && !stopMode |=> monitorFaultFlag && clockSelect &&
    !internalGenStable)
    else $error("internal loss not handled");
  flag_cov: cover property ($rose(monitorFaultFlag));
  ext_stable_cov: cover property ($rose(externalGenStable));
  stop_cov: cover property (stopMode && !cfgRunInStop);
endmodule

bind clock_gen_interlock clock_gen_interlock_asserts #(.MULT_W(MULT_W)) chk (
  .clk, .reset_n, .cfgExtInput, .cfgCrystal, .cfgLowFreq, .cfgRunInStop,
  .stopMode, .multWrite, .internalClockDead, .externalClockDead,
  .monitorIrqEnable, .monitorFaultFlag, .monitorOn, .clockSelect,
  .internalGenOn, .externalGenOn, .internalGenStable, .externalGenStable,
  .multiplier, .oscInputIsClock, .ampEnable, .monitorRange,
  .oscillatorOutputClock, .systemClockOut, .timebaseClock);

// File: sim/ext_clock_source.sv
module ext_clock_source #(
  parameter int HALF = 2
) (
  input wire logic clk, // Bus clock
  input wire logic enable, // External generator on
  input wire logic kill, // Commanded source failure
  output logic pinLevel, // Oscillator input pin level
  output logic edgePulse, // One pulse per source cycle
  output logic dead // Source stopped
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial pinLevel = 1'b0;
  initial edgePulse = 1'b0;
  // Source stands still while off or failed
  always @(negedge clk) begin
    edgePulse <= 1'b0;
    if (enable && !kill) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        pinLevel <= !pinLevel;
        edgePulse <= pinLevel;
      end
    end
  end
  assign dead = kill;
endmodule

// File: sim/clock_gen_interlock_tb_top.sv
module clock_gen_interlock_tb_top;
  import clock_gen_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, reset_n = 0, src = 0, kill = 0;
  logic cfgExtInput = 0, cfgCrystal = 0, cfgLowFreq = 0, cfgRunInStop = 0;
  logic stopMode = 0, ctrlWrite = 0, ctrlRead = 0, internalClockDead = 0;
  logic locked = 1;
  logic [5:0] wr = 0;
  logic [3:0] str = 0;
  logic [7:0] wdata = 0;
  int failures = 0, checked = 0;
  logic externalEdge, externalClockDead, oscInputPinIn, irqRequest;
  logic monitorIrqEnable, monitorFaultFlag, monitorOn, clockSelect;
  logic internalGenOn, externalGenOn, internalGenStable, externalGenStable;
  logic [6:0] multiplier;
  logic [7:0] adjustFactor, stage;
  logic [3:0] divider;
  logic oscInputIsClock, ampEnable, ampLowDrive, oscOutputPinOut;
  logic oscOutputPinOe, oscillatorOutputClock, systemClockOut, timebaseClock;
  monitor_range_t monitorRange;
  wire logic [7:0] st = {monitorIrqEnable, monitorFaultFlag, monitorOn,
    clockSelect, internalGenOn, externalGenOn, internalGenStable,
    externalGenStable};
  wire logic [7:0] pins = {3'h0, irqRequest, oscInputIsClock, ampEnable,
    ampLowDrive, oscOutputPinOe};
  wire logic [7:0] clks = {5'h0, oscillatorOutputClock, systemClockOut,
    timebaseClock};
  wire logic [7:0] rng = {6'h0, monitorRange};
  wire logic [7:0] mult = {1'b0, multiplier};
  always #12.5 clk = !clk;
  always @(negedge clk) src <= !src;
  clock_gen_interlock #(.LONG_COUNT(8), .SHORT_COUNT(2)) uut (
    .clk, .reset_n, .cfgExtInput, .cfgCrystal, .cfgLowFreq, .cfgRunInStop,
    .stopMode, .ctrlWrite, .wrIrqEnable(wr[5]), .wrFaultFlag(wr[4]),
    .wrMonitorOn(wr[3]), .wrClockSelect(wr[2]), .wrInternalOn(wr[1]),
    .wrExternalOn(wr[0]), .ctrlRead, .multWrite(str[0]),
    .multData(wdata[6:0]), .adjustWrite(str[1]), .adjustData(wdata),
    .divWrite(str[2]), .divData(wdata[3:0]), .stageWrite(str[3]),
    .stageData(wdata), .internalLocked(locked), .externalEdge,
    .internalClockDead, .externalClockDead, .oscInputPinIn,
    .portOutputData(1'b0), .portOutputEnable(1'b1), .srcOscClock(src),
    .srcSystemClock(src), .srcTimebaseClock(src), .monitorIrqEnable,
    .monitorFaultFlag, .monitorOn, .clockSelect, .internalGenOn,
    .externalGenOn, .internalGenStable, .externalGenStable, .multiplier,
    .adjustFactor, .divider, .stage, .oscInputIsClock, .ampEnable,
    .ampLowDrive, .monitorRange, .oscOutputPinOut, .oscOutputPinOe,
    .oscillatorOutputClock, .systemClockOut, .timebaseClock, .irqRequest);
  ext_clock_source #(.HALF(2)) xsrc (.clk, .enable(externalGenOn), .kill,
    .pinLevel(oscInputPinIn), .edgePulse(externalEdge),
    .dead(externalClockDead));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ctrl(input logic [5:0] v);
    wr = v;
    ctrlWrite = 1;
    tick(1);
    ctrlWrite = 0;
    tick(1);
  endtask
  task automatic strobe(input int k, input logic [7:0] d);
    wdata = d;
    str = 4'h1 << k;
    tick(1);
    str = 4'h0;
    tick(1);
  endtask
  task automatic rst(input logic [3:0] o);
    {cfgExtInput, cfgCrystal, cfgLowFreq, cfgRunInStop} = o;
    stopMode = 0;
    reset_n = 0;
    tick(10);
    reset_n = 1;
    tick(2);
  endtask
  task automatic close_out();
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25 * 2000);
    failures++;
    close_out();
  end
  initial begin
    rst(4'h0);
    chk(st, 8'h08);
    chk(mult, 8'h15);
    chk(adjustFactor, 8'h80);
    chk(pins, 8'h01);
    ctrl(6'h03);
    strobe(2, 8'h05);
    chk(st, 8'h08);
    chk({7'h0, divider === 4'h5}, 8'h00);
    stopMode = 1;
    tick(2);
    chk(clks, 8'h00);
    rst(4'hd);
    ctrl(6'h03);
    tick(12);
    chk({7'h0, externalGenStable}, 8'h00);
    tick(50);
    chk(st, 8'h0f);
    chk(pins, 8'h0d);
    chk(rng, 8'(RANGE_CRYSTAL));
    strobe(0, 8'h2a);
    strobe(1, 8'h3c);
    chk(st, 8'h0d);
    chk(mult, 8'h2a);
    chk(adjustFactor, 8'h3c);
    locked = 0;
    tick(2);
    chk({7'h0, internalGenStable}, 8'h00);
    locked = 1;
    tick(40);
    ctrl(6'h0b);
    ctrl(6'h2b);
    chk(st, 8'haf);
    strobe(0, 8'h11);
    chk(mult, 8'h2a);
    internalClockDead = 1;
    tick(2);
    internalClockDead = 0;
    chk(st, 8'hfd);
    chk(pins, 8'h1d);
    tick(40);
    ctrl(6'h2f);
    chk(st, 8'hff);
    ctrlRead = 1;
    tick(1);
    ctrlRead = 0;
    tick(1);
    ctrl(6'h2f);
    chk(st, 8'hbf);
    kill = 1;
    tick(2);
    chk(st, 8'hee);
    kill = 0;
    rst(4'ha);
    chk(rng, 8'(RANGE_EXT_SLOW));
    ctrl(6'h03);
    tick(12);
    chk({7'h0, externalGenStable}, 8'h01);
    chk(pins, 8'h09);
    tick(30);
    stopMode = 1;
    tick(2);
    chk(st, 8'h0c);
    chk(clks, 8'h00);
    close_out();
  end
endmodule
